// [hw/spfm_cfg.svh]
`ifndef SPFM_CFG_SVH
`define SPFM_CFG_SVH
// How it works
// - Thirty-two shared pins each carry at most one selected function at a time; selects above 4 pick none.
// - General I/O bits 4, 2 and 0 are input only: general I/O never drives them, F1..F4 alternates still can.
// - Card wait inputs go straight to the card controller, no enable bit.
// - Timer external clock pin feeds all three timer channels.
// - Serial external clock pin feeds both serial channels.
// - Byte-lane 3/2 strobes become card I/O write/read during card accesses.
// - Bits 23..21 carry serial peripheral clock, in, out, or trace status 2..4.
// - Bit 20 carries timer 0 out, highway frame sync, or trace status 1.
// - Bit 17 carries codec data in 0, NAND write strobe, or UART 1 transmit.
// - Bit 29 carries card 2 high select, chip enable 5, interrupt 7, trace 6.

// ****************************************
// Widths and select encodings
// ****************************************
`define SPFM_NPIO 32
`define SPFM_SELW 3
`define SPFM_SEL_GIO 3'h0
`define SPFM_SEL_F1 3'h1
`define SPFM_SEL_F2 3'h2
`define SPFM_SEL_F3 3'h3
`define SPFM_SEL_F4 3'h4
`define SPFM_IN_ONLY_MASK 32'h00000015
`define SPFM_OE_OFF 1'h1
`define SPFM_OE_ON 1'h0
`define SPFM_IDLE_HI 32'hffffffff
`define SPFM_INT_IDLE 8'hff
`define SPFM_PIN_WAIT1 24
`define SPFM_PIN_WAIT2 27
`define SPFM_PIN_TIMER_EXT_CLOCK 18
`define SPFM_PIN_SCLK 5
`define SPFM_PIN_INT7 29
`define SPFM_PIN_INT6 28
`define SPFM_PIN_INT5 15
`define SPFM_PIN_INT4 14
`define SPFM_PIN_INT3 9
`define SPFM_PIN_INT2 8
`define SPFM_PIN_INT1 7
`define SPFM_PIN_INT0 6
`endif

// [hw/spfm_pkg.sv]
package spfm_pkg;
  typedef logic [2:0] spfm_sel_type;
endpackage

// [hw/spfm_sync.sv]
`timescale 1ns/1ns
`include "spfm_cfg.svh"
// ****************************************
// Three-stage pin synchroniser, change accepted when stages two and three agree
// ****************************************
module spfm_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_async,
  output logic [31:0] o_sync
);
  logic [31:0] s1_reg;
  logic [31:0] s2_reg;
  logic [31:0] s3_reg;
  logic [31:0] out_reg;
  // Stage one feeds only stage two
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= 32'h0;
      s2_reg <= 32'h0;
      s3_reg <= 32'h0;
      out_reg <= 32'h0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
    end
  end
  assign o_sync = out_reg;
endmodule

// [hw/spfm_top.sv]
`timescale 1ns/1ns
`include "spfm_cfg.svh"
// ****************************************
// Shared pin function multiplexer
// ****************************************
module spfm_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [95:0] i_pin_sel,
  input wire logic [31:0] i_gio_out,
  input wire logic [31:0] i_gio_dir,
  output logic [31:0] o_gio_in,
  input wire logic [31:0] i_pad_in,
  output logic [31:0] o_pad_out,
  output logic [31:0] o_pad_oe_n,
  input wire logic [31:0] i_f1_out,
  input wire logic [31:0] i_f1_oe,
  input wire logic [31:0] i_f2_out,
  input wire logic [31:0] i_f2_oe,
  input wire logic [31:0] i_f3_out,
  input wire logic [31:0] i_f3_oe,
  input wire logic [31:0] i_f4_out,
  input wire logic [31:0] i_f4_oe,
  output logic [31:0] o_f1_in,
  output logic [31:0] o_f2_in,
  output logic [31:0] o_f3_in,
  output logic [31:0] o_f4_in,
  output logic o_card_slot1_wait_n,
  output logic o_card_slot2_wait_n,
  output logic o_timer_ext_clock,
  output logic o_serial_ext_clock,
  output logic [7:0] o_ext_int,
  input wire logic i_trace_status0,
  output logic o_trace_status0_pad,
  input wire logic i_card_access,
  input wire logic i_byte_lane3_strobe_n,
  input wire logic i_byte_lane2_strobe_n,
  input wire logic i_card_io_write_n,
  input wire logic i_card_io_read_n,
  output logic o_byte_lane3_strobe_n,
  output logic o_byte_lane2_strobe_n
);
  logic rst_s1_reg;
  logic rst_n_reg;
  logic [31:0] pin_sync;
  logic [31:0] out_next;
  logic [31:0] oe_n_next;
  logic [31:0] f1_in_next;
  logic [31:0] f2_in_next;
  logic [31:0] f3_in_next;
  logic [31:0] f4_in_next;
  logic [31:0] gio_in_next;
  logic [31:0] out_reg;
  logic [31:0] oe_n_reg;
  logic [31:0] f1_in_reg;
  logic [31:0] f2_in_reg;
  logic [31:0] f3_in_reg;
  logic [31:0] f4_in_reg;
  logic [31:0] gio_in_reg;
  logic [7:0] int_next;
  logic [7:0] int_reg;
  logic misc_wait1_reg;
  logic misc_wait2_reg;
  logic timer_ext_clock_reg;
  logic sclk_reg;
  logic trace0_reg;
  logic be3_reg;
  logic be2_reg;
  wire be3_next;
  wire be2_next;
  // Input-only mask held as a vector so each pin picks its own bit
  localparam logic [31:0] in_only_mask = `SPFM_IN_ONLY_MASK;

  // ****************************************
  // Reset release through two flops
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'h0;
      rst_n_reg <= 1'h0;
    end else begin
      rst_s1_reg <= 1'h1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // Pad inputs come from the board, so they are synchronised first
  spfm_sync u_sync (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n_reg),
    .i_async(i_pad_in),
    .o_sync(pin_sync)
  );

  // ****************************************
  // Per-pin selection
  // ****************************************
  // One select per pin; of the F1..F4 lanes only the chosen one hears the pin,
  // the others see an idle high; general I/O hears every pin regardless
  genvar gi;
  generate
    for (gi = 0; gi < `SPFM_NPIO; gi = gi + 1) begin : g_pin
      spfm_pkg::spfm_sel_type sel;
      wire in_only;
      wire is_gio;
      wire is_f1;
      wire is_f2;
      wire is_f3;
      wire is_f4;
      wire drv;
      assign sel = i_pin_sel[gi*`SPFM_SELW +: `SPFM_SELW];
      assign in_only = in_only_mask[gi];
      assign is_gio = (sel == `SPFM_SEL_GIO);
      assign is_f1 = (sel == `SPFM_SEL_F1);
      assign is_f2 = (sel == `SPFM_SEL_F2);
      assign is_f3 = (sel == `SPFM_SEL_F3);
      assign is_f4 = (sel == `SPFM_SEL_F4);
      // General I/O output blocked on input-only bits
      assign drv = is_gio ? (i_gio_dir[gi] & ~in_only) :
                   is_f1 ? i_f1_oe[gi] :
                   is_f2 ? i_f2_oe[gi] :
                   is_f3 ? i_f3_oe[gi] :
                   is_f4 ? i_f4_oe[gi] : 1'h0;
      assign out_next[gi] = is_gio ? i_gio_out[gi] :
                            is_f1 ? i_f1_out[gi] :
                            is_f2 ? i_f2_out[gi] :
                            is_f3 ? i_f3_out[gi] :
                            is_f4 ? i_f4_out[gi] : 1'h0;
      // Pad enable is active low, so an unselected pin floats to the board's level
      assign oe_n_next[gi] = drv ? `SPFM_OE_ON : `SPFM_OE_OFF;
      // Every pin stays readable as general I/O whatever its select
      assign gio_in_next[gi] = pin_sync[gi];
      // Bits 23..21, 20, 17, 29 hear their alternates through the F1..F4 lanes
      assign f1_in_next[gi] = is_f1 ? pin_sync[gi] : 1'h1;
      assign f2_in_next[gi] = is_f2 ? pin_sync[gi] : 1'h1;
      assign f3_in_next[gi] = is_f3 ? pin_sync[gi] : 1'h1;
      assign f4_in_next[gi] = is_f4 ? pin_sync[gi] : 1'h1;
    end
  endgenerate

  // Interrupt lines are wired straight through; software masks misuse
  // No gating here: a pin used for another function still toggles its line
  assign int_next = {pin_sync[`SPFM_PIN_INT7],
                     pin_sync[`SPFM_PIN_INT6],
                     pin_sync[`SPFM_PIN_INT5],
                     pin_sync[`SPFM_PIN_INT4],
                     pin_sync[`SPFM_PIN_INT3],
                     pin_sync[`SPFM_PIN_INT2],
                     pin_sync[`SPFM_PIN_INT1],
                     pin_sync[`SPFM_PIN_INT0]};

  // Card access swaps the byte strobes for the card I/O strobes
  // Registered so the pads move only on the clock edge, at one cycle of delay
  assign be3_next = i_card_access ? i_card_io_write_n : i_byte_lane3_strobe_n;
  assign be2_next = i_card_access ? i_card_io_read_n : i_byte_lane2_strobe_n;

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      out_reg <= 32'h0;
      oe_n_reg <= `SPFM_IDLE_HI;
      gio_in_reg <= 32'h0;
      f1_in_reg <= `SPFM_IDLE_HI;
      f2_in_reg <= `SPFM_IDLE_HI;
      f3_in_reg <= `SPFM_IDLE_HI;
      f4_in_reg <= `SPFM_IDLE_HI;
      int_reg <= `SPFM_INT_IDLE;
    end else begin
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
      gio_in_reg <= gio_in_next;
      f1_in_reg <= f1_in_next;
      f2_in_reg <= f2_in_next;
      f3_in_reg <= f3_in_next;
      f4_in_reg <= f4_in_next;
      int_reg <= int_next;
    end
  end

  // Dedicated taps plus trace and byte strobe flops: no enable bit, every tap consumer sees the pin regardless
  always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      misc_wait1_reg <= 1'h1;
      misc_wait2_reg <= 1'h1;
      timer_ext_clock_reg <= 1'h0;
      sclk_reg <= 1'h0;
      trace0_reg <= 1'h0;
      be3_reg <= 1'h1;
      be2_reg <= 1'h1;
    end else begin
      misc_wait1_reg <= pin_sync[`SPFM_PIN_WAIT1];
      misc_wait2_reg <= pin_sync[`SPFM_PIN_WAIT2];
      timer_ext_clock_reg <= pin_sync[`SPFM_PIN_TIMER_EXT_CLOCK];
      sclk_reg <= pin_sync[`SPFM_PIN_SCLK];
      trace0_reg <= i_trace_status0;
      be3_reg <= be3_next;
      be2_reg <= be2_next;
    end
  end

  // ****************************************
  // Output wiring, every port straight from a flop
  // ****************************************
  assign o_pad_out = out_reg;
  assign o_pad_oe_n = oe_n_reg;
  assign o_gio_in = gio_in_reg;
  assign o_f1_in = f1_in_reg;
  assign o_f2_in = f2_in_reg;
  assign o_f3_in = f3_in_reg;
  assign o_f4_in = f4_in_reg;
  assign o_ext_int = int_reg;
  assign o_card_slot1_wait_n = misc_wait1_reg;
  assign o_card_slot2_wait_n = misc_wait2_reg;
  assign o_timer_ext_clock = timer_ext_clock_reg;
  assign o_serial_ext_clock = sclk_reg;
  assign o_trace_status0_pad = trace0_reg;
  assign o_byte_lane3_strobe_n = be3_reg;
  assign o_byte_lane2_strobe_n = be2_reg;
endmodule

// [tb/spfm_board.sv]
`timescale 1ns/1ns
// ****
// Board side of the shared pads
// ****
module spfm_board (
  input wire logic [31:0] i_pad_out,
  input wire logic [31:0] i_pad_oe_n,
  input wire logic [31:0] i_drive,
  output logic [31:0] o_pad
);
  // Device wins where it drives, so a stray board value on a driven pad is masked
  assign o_pad = (i_pad_out & ~i_pad_oe_n) | (i_drive & i_pad_oe_n);
endmodule

// [tb/spfm_top_monitor.sv]
`timescale 1ns/1ns
// ****
// Pin mux checker
// ****
module spfm_top_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [95:0] i_pin_sel,
  input wire logic [31:0] i_gio_out,
  input wire logic [31:0] i_gio_dir,
  input wire logic [31:0] i_pad_in,
  input wire logic [31:0] o_pad_out,
  input wire logic [31:0] o_pad_oe_n,
  input wire logic [31:0] i_f2_out,
  input wire logic [31:0] i_f2_oe,
  input wire logic o_card_slot1_wait_n,
  input wire logic o_timer_ext_clock,
  input wire logic [7:0] o_ext_int,
  input wire logic i_card_access,
  input wire logic i_card_io_write_n,
  input wire logic i_card_io_read_n,
  input wire logic o_byte_lane3_strobe_n,
  input wire logic o_byte_lane2_strobe_n
);
  logic [3:0] up_reg;
  logic rdy;
  // Hold checks off until the internal reset copy has long settled
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) up_reg <= 4'h0;
    else if (up_reg != 4'hf) up_reg <= up_reg + 4'h1;
  end
  assign rdy = (up_reg == 4'hf);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Pad quiet long enough to cross the synchroniser
  sequence s_quiet(logic b);
    $stable(b) [*7];
  endsequence
  property p_in_only;
    rdy && $past(i_pin_sel[2:0] == 3'h0) |-> o_pad_oe_n[0];
  endproperty
  property p_gio_drive;
    rdy && $past(i_pin_sel[5:3] == 3'h0 && i_gio_dir[1])
      |-> !o_pad_oe_n[1] && o_pad_out[1] == $past(i_gio_out[1]);
  endproperty
  property p_f2_20;
    rdy && $past(i_pin_sel[62:60] == 3'h2 && i_f2_oe[20])
      |-> !o_pad_oe_n[20] && o_pad_out[20] == $past(i_f2_out[20]);
  endproperty
  property p_bad_sel;
    rdy && $past(i_pin_sel[5:3] > 3'h4) |-> o_pad_oe_n[1];
  endproperty
  property p_card;
    rdy && $past(i_card_access) |-> o_byte_lane3_strobe_n == $past(i_card_io_write_n)
      && o_byte_lane2_strobe_n == $past(i_card_io_read_n);
  endproperty
  property p_wait1;
    s_quiet(i_pad_in[24]) ##0 rdy |-> o_card_slot1_wait_n == i_pad_in[24];
  endproperty
  property p_timer_ext_clock;
    s_quiet(i_pad_in[18]) ##0 rdy |-> o_timer_ext_clock == i_pad_in[18];
  endproperty
  property p_int7;
    s_quiet(i_pad_in[29]) ##0 rdy |-> o_ext_int[7] == i_pad_in[29];
  endproperty
  a_in_only: assert property (p_in_only) else $error("input-only pin driven");
  a_gio_drive: assert property (p_gio_drive) else $error("gio drive wrong");
  a_f2_20: assert property (p_f2_20) else $error("pin 20 alt wrong");
  a_bad_sel: assert property (p_bad_sel) else $error("bad select drives");
  a_card: assert property (p_card) else $error("card strobe wrong");
  a_wait1: assert property (p_wait1) else $error("wait tap wrong");
  a_timer_ext_clock: assert property (p_timer_ext_clock) else $error("timer clock tap wrong");
  a_int7: assert property (p_int7) else $error("interrupt tap wrong");
endmodule
bind spfm_top spfm_top_monitor i_spfm_top_monitor (.i_ref_clk, .i_rst_n, .i_pin_sel,
  .i_gio_out, .i_gio_dir, .i_pad_in, .o_pad_out, .o_pad_oe_n, .i_f2_out, .i_f2_oe,
  .o_card_slot1_wait_n, .o_timer_ext_clock, .o_ext_int, .i_card_access,
  .i_card_io_write_n, .i_card_io_read_n, .o_byte_lane3_strobe_n, .o_byte_lane2_strobe_n);

// [tb/tb.sv]
`timescale 1ns/1ns
// ****
// Pin mux bench
// ****
module tb;
  logic i_ref_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic [95:0] sel = 96'h0;
  logic [31:0] gout = 32'h0, gdir = 32'h0, ext = 32'h0, e, m, f;
  logic [31:0] fo [4];
  logic [31:0] fe [4];
  logic ca = 1'h0, b3 = 1'h1, b2 = 1'h1, wr = 1'h1, rd = 1'h1, t0 = 1'h0;
  logic [31:0] pad, gin, pout, poe, fi1, fi2, fi3, fi4;
  logic w1, w2, tck, sck, t0p, o3, o2;
  logic [7:0] eint;
  int num_errors = 0, n_tests = 0;
  localparam logic [31:0] M = 32'h20f20000;
  always #25 i_ref_clk = ~i_ref_clk;
  spfm_top i_spfm_top (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_pin_sel(sel),
    .i_gio_out(gout), .i_gio_dir(gdir), .o_gio_in(gin), .i_pad_in(pad), .o_pad_out(pout),
    .o_pad_oe_n(poe), .i_f1_out(fo[0]), .i_f1_oe(fe[0]), .i_f2_out(fo[1]), .i_f2_oe(fe[1]),
    .i_f3_out(fo[2]), .i_f3_oe(fe[2]), .i_f4_out(fo[3]), .i_f4_oe(fe[3]), .o_f1_in(fi1),
    .o_f2_in(fi2), .o_f3_in(fi3), .o_f4_in(fi4), .o_card_slot1_wait_n(w1),
    .o_card_slot2_wait_n(w2), .o_timer_ext_clock(tck), .o_serial_ext_clock(sck),
    .o_ext_int(eint), .i_trace_status0(t0), .o_trace_status0_pad(t0p), .i_card_access(ca),
    .i_byte_lane3_strobe_n(b3), .i_byte_lane2_strobe_n(b2), .i_card_io_write_n(wr),
    .i_card_io_read_n(rd), .o_byte_lane3_strobe_n(o3), .o_byte_lane2_strobe_n(o2));
  spfm_board i_spfm_board (.i_pad_out(pout), .i_pad_oe_n(poe), .i_drive(ext), .o_pad(pad));
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task end_sim;
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Settle a little after the edge so registered outputs have landed
  task cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Whole run is about a hundred cycles; this allows 4000 cycles, near forty times that
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
  initial begin
    foreach (fo[j]) begin
      fo[j] = 32'h0;
      fe[j] = 32'h0;
    end
    repeat (16) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    cyc(4);
    chk(poe, 32'hffffffff);
    chk(fi1, 32'hffffffff);
    @(posedge i_ref_clk);
    gdir <= 32'hffffffff;
    gout <= 32'haaaaaaaa;
    cyc(2);
    chk(poe, 32'h00000015);
    chk(pout & 32'hffffffea, 32'haaaaaaaa);
    // Alternates 1, 2 exist on every pin of M; 3 only on 29, 20, 17; 4 only on 29
    for (int k = 1; k <= 4; k++) begin
      m = (k == 4) ? 32'h20000000 : (k == 3) ? 32'h20120000 : M;
      @(posedge i_ref_clk);
      sel <= {32{k[2:0]}};
      foreach (fo[j]) begin
        fo[j] <= {32{j == k - 1}};
        fe[j] <= {32{j == k - 1}};
      end
      cyc(2);
      chk(pout & m, m);
      chk(poe & m, 32'h0);
      @(posedge i_ref_clk);
      fe[k - 1] <= 32'h0;
      ext <= (k == 1) ? 32'h00400000 : (k == 2) ? 32'h20020000 :
             (k == 3) ? 32'h00100000 : 32'h20000000;
      cyc(8);
      f = (k == 1) ? fi1 : (k == 2) ? fi2 : (k == 3) ? fi3 : fi4;
      chk(f & m, ext & m);
      chk((k == 3) ? fi4 : fi3, 32'hffffffff);
    end
    @(posedge i_ref_clk);
    sel <= {32{3'h5}};
    cyc(8);
    chk(poe, 32'hffffffff);
    chk(fi1, 32'hffffffff);
    // Taps and interrupt lines read and checked with every pin an input
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      sel <= 96'h0;
      gdir <= 32'h0;
      e = k ? 32'ha5a5a5a5 : 32'h5a5a5a5a;
      ext <= e;
      cyc(8);
      chk(gin, e);
      chk({28'h0, w2, w1, tck, sck}, {28'h0, e[27], e[24], e[18], e[5]});
      chk({24'h0, eint}, {24'h0, e[29:28], e[15:14], e[9:6]});
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      ca <= k[0];
      t0 <= k[0];
      b3 <= 1'h0;
      rd <= 1'h0;
      cyc(2);
      chk({30'h0, o3, o2}, k ? 32'h2 : 32'h1);
      chk({31'h0, t0p}, {31'h0, k[0]});
    end
    end_sim;
  end
endmodule
